// file: src/blc_regbank.sv
`timescale 1ns/1ns
`include "blc_defines.svh"
module blc_regbank
    import blc_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h1, // arbitrary value
    parameter int RAMP_BASE_CYC = `BLC_RAMP_BASE_CYC
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE,
    input wire logic I_PWM_IN,
    input wire logic [10:0] I_PWM_DUTY,
    input wire logic I_CEILING_INPUT,
    output logic O_DEVICE_ENABLE,
    output logic O_STRING_SINK_ONE,
    output logic O_STRING_SINK_TWO,
    output logic O_STRING_SINK_THREE,
    output logic [10:0] O_BRIGHTNESS_CODE,
    output logic O_MAP_EXPONENTIAL,
    output logic O_PWM_FILTERED,
    output logic [1:0] O_PWM_SAMPLE_SEL,
    output logic O_FREQ_SHIFT_OFF,
    output logic O_FREQ_1MHZ,
    output logic O_INDUCTOR_SEL,
    output logic [1:0] O_OVERVOLTAGE_LIMIT,
    output logic [1:0] O_OVERCURRENT_LIMIT,
    output logic O_AUTO_FREQ_HIGH,
    output logic O_AUTO_FREQ_LOW
);

    // ****************************************
    // i2c slave
    // ****************************************
    blc_i2c_state_e state;
    logic scl_q, sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] reg_ptr;
    logic sda_low;
    logic wr_en;
    logic [7:0] wr_addr, wr_data;
    logic [7:0] rd_byte;
    logic scl_rise, scl_fall, bus_start, bus_stop, byte_done;

    assign scl_rise = I_SCL & ~scl_q;
    assign scl_fall = ~I_SCL & scl_q;
    assign bus_start = I_SCL & scl_q & sda_q & ~I_SDA;
    assign bus_stop = I_SCL & scl_q & ~sda_q & I_SDA;
    assign byte_done = scl_fall && (bit_cnt == 4'h8);
    assign O_SDA = 1'b0;
    assign O_SDA_OE = sda_low;

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= I_SCL;
            sda_q <= I_SDA;
        end
    end

    // the engine is kept out of the soft reset so the ack of that byte completes
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            state <= BLC_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            reg_ptr <= 8'h00;
            sda_low <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (bus_start) begin
                state <= BLC_ADDR;
                bit_cnt <= 4'h0;
                sda_low <= 1'b0;
            end else if (bus_stop) begin
                state <= BLC_IDLE;
                sda_low <= 1'b0;
            end else begin
                case (state)
                    BLC_ADDR, BLC_REG, BLC_WDATA: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], I_SDA};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt <= 4'h0;
                            if (state == BLC_ADDR) begin
                                if (shreg[7:1] == `BLC_I2C_ADDR) begin
                                    state <= BLC_ACK_ADDR;
                                    sda_low <= 1'b1;
                                end else begin
                                    state <= BLC_IDLE;
                                end
                            end else if (state == BLC_REG) begin
                                reg_ptr <= shreg;
                                state <= BLC_ACK_REG;
                                sda_low <= 1'b1;
                            end else begin
                                wr_en <= 1'b1;
                                wr_addr <= reg_ptr;
                                wr_data <= shreg;
                                state <= BLC_ACK_DATA;
                                sda_low <= 1'b1;
                            end
                        end
                    end
                    BLC_ACK_ADDR: begin
                        if (scl_fall) begin
                            if (shreg[0]) begin
                                state <= BLC_RDATA;
                                shreg <= rd_byte;
                                sda_low <= ~rd_byte[7];
                            end else begin
                                state <= BLC_REG;
                                sda_low <= 1'b0;
                            end
                        end
                    end
                    BLC_ACK_REG, BLC_ACK_DATA: begin
                        if (scl_fall) begin
                            if (state == BLC_ACK_DATA) begin
                                reg_ptr <= reg_ptr + 8'h01;
                            end
                            state <= BLC_WDATA;
                            sda_low <= 1'b0;
                        end
                    end
                    BLC_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            state <= BLC_RACK;
                            sda_low <= 1'b0;
                            bit_cnt <= 4'h0;
                        end else if (scl_fall) begin
                            sda_low <= ~shreg[3'(4'h7 - bit_cnt)];
                        end
                    end
                    BLC_RACK: begin
                        if (scl_rise && I_SDA) begin
                            state <= BLC_IDLE;
                        end else if (scl_fall) begin
                            state <= BLC_RDATA;
                            reg_ptr <= reg_ptr + 8'h01;
                            shreg <= rd_byte;
                            sda_low <= ~rd_byte[7];
                        end
                    end
                    default: begin
                        sda_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic soft_rst, rst_regs, en_rise;
    logic [3:0] enable_control;
    logic [7:0] brightness_config, pwm_input_config;
    logic [6:0] boost_config;
    logic [7:0] auto_freq_upper_threshold, auto_freq_lower_threshold, ceiling_threshold;
    logic [2:0] brightness_code_low;
    logic [7:0] brightness_code_high;

    assign rst_regs = I_RST | soft_rst;
    assign en_rise = wr_en && wr_addr == `BLC_ADDR_ENABLE && wr_data[`BLC_EN_DEVICE]
        && !enable_control[`BLC_EN_DEVICE];

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_en && wr_addr == `BLC_ADDR_SOFT_RESET && wr_data[0];
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs) begin
            enable_control <= `BLC_RST_ENABLE;
            brightness_config <= `BLC_RST_BRIGHT_CFG;
            pwm_input_config <= `BLC_RST_PWM_CFG;
            boost_config <= `BLC_RST_BOOST_CFG;
            auto_freq_upper_threshold <= `BLC_RST_AF_HIGH;
            auto_freq_lower_threshold <= `BLC_RST_AF_LOW;
            ceiling_threshold <= `BLC_RST_CEILING;
            brightness_code_low <= `BLC_RST_CODE_LOW;
            brightness_code_high <= `BLC_RST_CODE_HIGH;
        end else if (wr_en) begin
            case (wr_addr)
                `BLC_ADDR_ENABLE: enable_control <= wr_data[3:0];
                `BLC_ADDR_BRIGHT_CFG: brightness_config <= wr_data;
                `BLC_ADDR_PWM_CFG: pwm_input_config <= wr_data;
                `BLC_ADDR_BOOST_CFG: boost_config <= wr_data[6:0];
                `BLC_ADDR_AF_HIGH: auto_freq_upper_threshold <= wr_data;
                `BLC_ADDR_AF_LOW: auto_freq_lower_threshold <= wr_data;
                `BLC_ADDR_CEILING: ceiling_threshold <= wr_data;
                `BLC_ADDR_CODE_LOW: brightness_code_low <= wr_data[2:0];
                `BLC_ADDR_CODE_HIGH: brightness_code_high <= wr_data;
                default: begin
                end
            endcase
            if (en_rise) begin
                brightness_config[`BLC_BC_CEIL_POL] <= 1'(`BLC_RST_BRIGHT_CFG >> `BLC_BC_CEIL_POL);
                pwm_input_config <= `BLC_RST_PWM_CFG;
            end
        end
    end

    // unused bits are simply not stored, so they cannot read back as anything but zero
    function automatic logic [7:0] reg_read(input logic [7:0] a);
        case (a)
            `BLC_ADDR_REVISION: reg_read = {4'h0, REVISION};
            `BLC_ADDR_ENABLE: reg_read = {4'h0, enable_control};
            `BLC_ADDR_BRIGHT_CFG: reg_read = brightness_config;
            `BLC_ADDR_PWM_CFG: reg_read = pwm_input_config;
            `BLC_ADDR_BOOST_CFG: reg_read = {1'b0, boost_config};
            `BLC_ADDR_AF_HIGH: reg_read = auto_freq_upper_threshold;
            `BLC_ADDR_AF_LOW: reg_read = auto_freq_lower_threshold;
            `BLC_ADDR_CEILING: reg_read = ceiling_threshold;
            `BLC_ADDR_CODE_LOW: reg_read = {5'h00, brightness_code_low};
            `BLC_ADDR_CODE_HIGH: reg_read = brightness_code_high;
            default: reg_read = 8'h00;
        endcase
    endfunction

    always_comb begin
        rd_byte = reg_read(state == BLC_RACK ? reg_ptr + 8'h01 : reg_ptr);
    end

    assign O_DEVICE_ENABLE = enable_control[0];
    assign O_STRING_SINK_ONE = enable_control[1];
    assign O_STRING_SINK_TWO = enable_control[2];
    assign O_STRING_SINK_THREE = enable_control[3];
    assign O_MAP_EXPONENTIAL = brightness_config[`BLC_BC_MAP];
    assign O_PWM_SAMPLE_SEL = pwm_input_config[7:6];
    assign O_FREQ_SHIFT_OFF = boost_config[6];
    assign O_FREQ_1MHZ = boost_config[5];
    assign O_INDUCTOR_SEL = boost_config[4];
    assign O_OVERVOLTAGE_LIMIT = boost_config[3:2];
    assign O_OVERCURRENT_LIMIT = boost_config[1:0];

    // ****************************************
    // pwm input conditioning
    // ****************************************
    logic pwm_level, pwm_raw_q;
    logic [4:0] filt_cnt;
    logic [4:0] filt_len;
    blc_code_t duty_held;
    blc_code_t duty_diff;

    assign pwm_level = I_PWM_IN ~^ pwm_input_config[`BLC_PWM_POL];

    always_comb begin
        case (pwm_input_config[1:0])
            2'b01: filt_len = 5'(`BLC_FILT_A_CYC);
            2'b10: filt_len = 5'(`BLC_FILT_B_CYC);
            2'b11: filt_len = 5'(`BLC_FILT_C_CYC);
            default: filt_len = 5'h00;
        endcase
    end

    // with a filter selected, a level shorter than the filter length never reaches the output; filter select 00 passes every level
    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs) begin
            pwm_raw_q <= 1'b0;
            filt_cnt <= 5'h00;
            O_PWM_FILTERED <= 1'b0;
        end else begin
            pwm_raw_q <= pwm_level;
            if (pwm_level != pwm_raw_q) begin
                filt_cnt <= 5'h00;
            end else if (filt_cnt != 5'h1f) begin
                filt_cnt <= filt_cnt + 5'h01;
            end
            if (filt_len == 5'h00 || (pwm_level == pwm_raw_q && filt_cnt >= filt_len - 5'h01)) begin
                O_PWM_FILTERED <= pwm_level;
            end
        end
    end

    assign duty_diff = (I_PWM_DUTY > duty_held) ? I_PWM_DUTY - duty_held : duty_held - I_PWM_DUTY;

    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs) begin
            duty_held <= 11'h000;
        end else if (duty_diff > {8'h00, pwm_input_config[4:2]}) begin
            duty_held <= I_PWM_DUTY;
        end
    end

    // ****************************************
    // brightness path
    // ****************************************
    logic ceil_active, ramp_tick;
    logic [23:0] ramp_cnt, step_len;
    blc_code_t reg_code, ramp_in, ramp_q, ramped, final_code;

    function automatic blc_code_t scale(input blc_code_t a, input blc_code_t b);
        logic [21:0] p;
        p = a * b;
        scale = p[21:11];
    endfunction

    assign ceil_active = I_CEILING_INPUT ~^ brightness_config[`BLC_BC_CEIL_POL];
    assign reg_code = {ceil_active ? ceiling_threshold : brightness_code_high, brightness_code_low};
    assign step_len = 24'(RAMP_BASE_CYC) << brightness_config[3:1];
    assign ramp_tick = ramp_cnt >= step_len - 24'h000001;

    always_comb begin
        case (brightness_config[6:5])
            2'b00: ramp_in = reg_code;
            2'b01: ramp_in = duty_held;
            2'b10: ramp_in = scale(reg_code, duty_held);
            default: ramp_in = reg_code;
        endcase
        ramped = brightness_config[`BLC_BC_RAMP_EN] ? ramp_q : ramp_in;
        final_code = (brightness_config[6:5] == 2'b11) ? scale(ramped, duty_held) : ramped;
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs || ramp_tick) begin
            ramp_cnt <= 24'h000000;
        end else begin
            ramp_cnt <= ramp_cnt + 24'h000001;
        end
    end

    // with ramping off the ramp follows its input so enabling it causes no jump
    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs) begin
            ramp_q <= 11'h7ff;
        end else if (!brightness_config[`BLC_BC_RAMP_EN]) begin
            ramp_q <= ramp_in;
        end else if (ramp_tick && ramp_q < ramp_in) begin
            ramp_q <= ramp_q + 11'h001;
        end else if (ramp_tick && ramp_q > ramp_in) begin
            ramp_q <= ramp_q - 11'h001;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (rst_regs) begin
            O_BRIGHTNESS_CODE <= 11'h7ff;
            O_AUTO_FREQ_HIGH <= 1'b0;
            O_AUTO_FREQ_LOW <= 1'b0;
        end else begin
            O_BRIGHTNESS_CODE <= final_code;
            O_AUTO_FREQ_HIGH <= final_code[10:3] > auto_freq_upper_threshold;
            O_AUTO_FREQ_LOW <= final_code[10:3] > auto_freq_lower_threshold;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    sequence data_byte_done;
        state == BLC_WDATA && byte_done;
    endsequence
    sequence swrst_write;
        wr_en && wr_addr == `BLC_ADDR_SOFT_RESET && wr_data[0];
    endsequence

    chk_unmapped_zero: assert property (reg_ptr == 8'h02 && state != BLC_RACK |-> rd_byte == 8'h00)
        else $error("unmapped register read not zero");
    chk_code_low_zero: assert property (reg_ptr == `BLC_ADDR_CODE_LOW && state != BLC_RACK
        |-> rd_byte[7:3] == 5'h00)
        else $error("reserved bits read not zero");
    chk_swrst_self_clear: assert property (swrst_write |=> soft_rst ##1 !soft_rst)
        else $error("soft reset pulse wrong");
    chk_swrst_defaults: assert property (soft_rst
        |=> brightness_code_high == 8'hff && enable_control == 4'hf)
        else $error("soft reset did not restore defaults");
    chk_enable_restore: assert property (en_rise && !soft_rst
        |=> pwm_input_config == 8'h73 && brightness_config[0])
        else $error("device enable did not restore pwm config");
    chk_ceiling_force: assert property (I_CEILING_INPUT == brightness_config[`BLC_BC_CEIL_POL]
        && brightness_config[6:4] == 3'b000 && !soft_rst |=> O_BRIGHTNESS_CODE[10:3] == $past(ceiling_threshold))
        else $error("ceiling not forced");
    chk_reg_only_path: assert property (brightness_config[6:4] == 3'b000 && !soft_rst
        |=> O_BRIGHTNESS_CODE == $past(reg_code))
        else $error("register-only code not passed");
    chk_ramp_single_step: assert property (brightness_config[4] && ramp_tick && ramp_q < ramp_in
        && !soft_rst |=> ramp_q == $past(ramp_q) + 11'h001)
        else $error("ramp step wrong");
    chk_ramp_hold: assert property (brightness_config[4] && !ramp_tick && !soft_rst |=> $stable(ramp_q))
        else $error("ramp moved between ticks");
    chk_data_ack: assert property (data_byte_done and !bus_start and !bus_stop |=> wr_en && sda_low)
        else $error("data byte not written and acked");
    chk_hyst_hold: assert property (duty_diff <= {8'h00, pwm_input_config[4:2]} && !soft_rst
        |=> $stable(duty_held))
        else $error("duty moved inside hysteresis");

endmodule

// file: src/blc_defines.svh
`ifndef BLC_DEFINES_SVH
`define BLC_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define BLC_ADDR_REVISION 8'h00
`define BLC_ADDR_SOFT_RESET 8'h01
`define BLC_ADDR_ENABLE 8'h10
`define BLC_ADDR_BRIGHT_CFG 8'h11
`define BLC_ADDR_PWM_CFG 8'h12
`define BLC_ADDR_BOOST_CFG 8'h13
`define BLC_ADDR_AF_HIGH 8'h15
`define BLC_ADDR_AF_LOW 8'h16
`define BLC_ADDR_CEILING 8'h17
`define BLC_ADDR_CODE_LOW 8'h18
`define BLC_ADDR_CODE_HIGH 8'h19

// ****************************************
// reset values
// ****************************************
`define BLC_RST_ENABLE 4'hf
`define BLC_RST_BRIGHT_CFG 8'h61
`define BLC_RST_PWM_CFG 8'h73
`define BLC_RST_BOOST_CFG 7'h6f
`define BLC_RST_AF_HIGH 8'h00
`define BLC_RST_AF_LOW 8'h00
`define BLC_RST_CEILING 8'h00
`define BLC_RST_CODE_LOW 3'h7
`define BLC_RST_CODE_HIGH 8'hff

// ****************************************
// field positions
// ****************************************
`define BLC_EN_DEVICE 0
`define BLC_BC_CEIL_POL 0
`define BLC_BC_RAMP_EN 4
`define BLC_BC_MAP 7
`define BLC_PWM_POL 5

// ****************************************
// bus and timing
// ****************************************
`define BLC_I2C_ADDR 7'h36
`define BLC_CLK_NS 8
`define BLC_RAMP_BASE_NS 125000
`define BLC_RAMP_BASE_CYC (`BLC_RAMP_BASE_NS / `BLC_CLK_NS)
`define BLC_FILT_A_NS 100
`define BLC_FILT_B_NS 150
`define BLC_FILT_C_NS 200
`define BLC_FILT_A_CYC ((`BLC_FILT_A_NS + `BLC_CLK_NS - 1) / `BLC_CLK_NS)
`define BLC_FILT_B_CYC ((`BLC_FILT_B_NS + `BLC_CLK_NS - 1) / `BLC_CLK_NS)
`define BLC_FILT_C_CYC ((`BLC_FILT_C_NS + `BLC_CLK_NS - 1) / `BLC_CLK_NS)

`endif

// file: src/blc_pkg.sv
package blc_pkg;
    typedef logic [10:0] blc_code_t;
    typedef enum logic [3:0] {
        BLC_IDLE,
        BLC_ADDR,
        BLC_ACK_ADDR,
        BLC_REG,
        BLC_ACK_REG,
        BLC_WDATA,
        BLC_ACK_DATA,
        BLC_RDATA,
        BLC_RACK
    } blc_i2c_state_e;
endpackage

// file: dv/blc_host_model.sv
`timescale 1ns/1ns
`include "blc_defines.svh"
// ****************************************
// i2c host on the register bus
// ****************************************
module blc_host_model (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial o_scl = 1'b1;
    initial o_sda = 1'b1;
    task automatic hc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // 4 clocks per phase, above the 1 the engine needs to see a level
    task automatic cond(input logic first, input logic last, input logic scl_end);
        o_sda = first;
        hc(4);
        o_scl = 1'b1;
        hc(4);
        o_sda = last;
        hc(4);
        o_scl = scl_end;
        hc(4);
    endtask
    // sda only moves one clock after scl fell, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        o_sda = b;
        hc(4);
        o_scl = 1'b1;
        hc(4);
        r = i_sda;
        o_scl = 1'b0;
        hc(1);
    endtask
    task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic na);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, na);
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] adr, input logic [7:0] dat, output logic ok);
        logic [7:0] q;
        logic n0, n1, n2;
        cond(1'b1, 1'b0, 1'b0);
        byte_io({dev, 1'b0}, 1'b1, q, n0);
        byte_io(adr, 1'b1, q, n1);
        byte_io(dat, 1'b1, q, n2);
        cond(1'b0, 1'b1, 1'b1);
        ok = !(n0 | n1 | n2);
    endtask
    task automatic read_reg(input logic [7:0] adr, output logic [7:0] q);
        logic [7:0] x;
        logic n;
        cond(1'b1, 1'b0, 1'b0);
        byte_io({`BLC_I2C_ADDR, 1'b0}, 1'b1, x, n);
        byte_io(adr, 1'b1, x, n);
        cond(1'b1, 1'b0, 1'b0);
        byte_io({`BLC_I2C_ADDR, 1'b1}, 1'b1, x, n);
        byte_io(8'hff, 1'b1, q, n);
        cond(1'b0, 1'b1, 1'b1);
    endtask
endmodule

// file: dv/backlight_control_register_bank_tb.sv
`timescale 1ns/1ns
`include "blc_defines.svh"
// ****************************************
// register bank bench
// ****************************************
module backlight_control_register_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwm_in = 1'b0;
    logic ceil_in = 1'b0;
    logic scl, hsda, sda_w, sda_o, sda_oe, dev_en, sink1, map_exp, pwm_f, shift_off, f1m, ind, af_hi, af_lo, ok;
    logic [1:0] smp, overvoltage_limit, overcurrent_limit;
    logic [10:0] code, c0;
    logic [10:0] duty = 11'h234;
    logic sink2, sink3;
    logic [7:0] rd;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    // pull-up: the wire is low only while someone drives it low
    assign sda_w = hsda & (sda_oe ? sda_o : 1'b1);
    initial forever #4 clk = ~clk;
    blc_host_model blc_host_model_inst (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(hsda));
    blc_regbank #(.RAMP_BASE_CYC(4)) blc_regbank_inst (.I_REF_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_w),
        .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_PWM_IN(pwm_in), .I_PWM_DUTY(duty), .I_CEILING_INPUT(ceil_in),
        .O_DEVICE_ENABLE(dev_en), .O_STRING_SINK_ONE(sink1), .O_STRING_SINK_TWO(sink2), .O_STRING_SINK_THREE(sink3),
        .O_BRIGHTNESS_CODE(code), .O_MAP_EXPONENTIAL(map_exp), .O_PWM_FILTERED(pwm_f), .O_PWM_SAMPLE_SEL(smp),
        .O_FREQ_SHIFT_OFF(shift_off), .O_FREQ_1MHZ(f1m), .O_INDUCTOR_SEL(ind), .O_OVERVOLTAGE_LIMIT(overvoltage_limit),
        .O_OVERCURRENT_LIMIT(overcurrent_limit), .O_AUTO_FREQ_HIGH(af_hi), .O_AUTO_FREQ_LOW(af_lo));
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // 50 register accesses of under 500 clocks each
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic hc(input int n);
        blc_host_model_inst.hc(n);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        blc_host_model_inst.write_reg(`BLC_I2C_ADDR, a, d, ok);
        chk("ack", 11'h1, {10'h0, ok});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        blc_host_model_inst.read_reg(a, rd);
        chk($sformatf("reg_%h", a), {3'h0, exp}, {3'h0, rd});
    endtask
    task automatic t_reset();
        logic [7:0] adr [12] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
        logic [7:0] val [12] = '{8'h01, 8'h00, 8'h0f, 8'h61, 8'h73, 8'h6f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hff};
        for (int i = 0; i < 12; i++) begin
            rdc(adr[i], val[i]);
        end
        chk("sample_sel", 11'h1, {9'h0, smp});
        chk("boost", 11'h6f, {4'h0, shift_off, f1m, ind, overvoltage_limit, overcurrent_limit});
        wr(8'h13, 8'h80);
        chk("boost", 11'h0, {4'h0, shift_off, f1m, ind, overvoltage_limit, overcurrent_limit});
        rdc(8'h13, 8'h00);
        wr(8'h18, 8'hfd);
        rdc(8'h18, 8'h05);
        wr(8'h00, 8'hff);
        rdc(8'h00, 8'h01);
    endtask
    task automatic t_code();
        wr(8'h10, 8'h01);
        wr(8'h11, 8'h81);
        wr(8'h19, 8'ha5);
        wr(8'h18, 8'h03);
        hc(20);
        chk("code", 11'h52b, code);
        chk("map", 11'h1, {10'h0, map_exp});
        wr(8'h15, 8'ha4);
        wr(8'h16, 8'ha5);
        hc(4);
        chk("auto_freq", 11'h2, {9'h0, af_hi, af_lo});
        wr(8'h17, 8'h12);
        ceil_in = 1'b1;
        hc(8);
        chk("code", 11'h093, code);
        ceil_in = 1'b0;
        wr(8'h11, 8'h80);
        hc(8);
        chk("code", 11'h093, code);
        wr(8'h11, 8'ha1);
        hc(20);
        chk("code", 11'h234, code);
    endtask
    task automatic t_enable();
        wr(8'h12, 8'h00);
        wr(8'h11, 8'ha0);
        wr(8'h10, 8'h00);
        chk("dev_en", 11'h0, {10'h0, dev_en});
        wr(8'h10, 8'h01);
        rdc(8'h12, 8'h73);
        rdc(8'h11, 8'ha1);
        chk("sinks", 11'h0, {8'h0, sink3, sink2, sink1});
    endtask
    task automatic t_soft();
        wr(8'h19, 8'h00);
        wr(8'h01, 8'h01);
        rdc(8'h01, 8'h00);
        rdc(8'h19, 8'hff);
        rdc(8'h10, 8'h0f);
        chk("sinks", 11'h7, {8'h0, sink3, sink2, sink1});
        blc_host_model_inst.write_reg(7'h37, 8'h19, 8'h00, ok);
        chk("nack", 11'h0, {10'h0, ok});
        rdc(8'h19, 8'hff);
    endtask
    task automatic t_pwm();
        wr(8'h10, 8'h01);
        pwm_in = 1'b1;
        hc(40);
        chk("pwm", 11'h1, {10'h0, pwm_f});
        pwm_in = 1'b0;
        hc(10);
        chk("pwm_glitch", 11'h1, {10'h0, pwm_f});
        pwm_in = 1'b1;
        wr(8'h12, 8'hd3);
        hc(40);
        chk("pwm", 11'h0, {10'h0, pwm_f});
        chk("sample_sel", 11'h3, {9'h0, smp});
        wr(8'h11, 8'h21);
        duty = 11'h238;
        hc(4);
        chk("duty", 11'h234, code);
        duty = 11'h239;
        hc(4);
        chk("duty", 11'h239, code);
    endtask
    // strings stay off from the previous scenario; 4 clocks per step at rate 000
    task automatic t_ramp();
        wr(8'h11, 8'h01);
        wr(8'h18, 8'h00);
        wr(8'h19, 8'h00);
        wr(8'h11, 8'h11);
        wr(8'h19, 8'h10);
        c0 = code;
        hc(40);
        chk("ramp_up", c0 + 11'h00a, code);
        hc(600);
        chk("ramp_end", 11'h080, code);
        wr(8'h11, 8'h15);
        wr(8'h19, 8'h00);
        c0 = code;
        hc(64);
        chk("ramp_down", c0 - 11'h004, code);
    endtask
    initial begin
        hc(8);
        rst = 1'b0;
        hc(2);
        t_reset();
        t_code();
        t_enable();
        t_soft();
        t_pwm();
        t_ramp();
        complete_run();
    end
endmodule
